//--- hw/hbf_map.svh
// Timing counts, current-limit figures and status bit positions.
// Assumes a single 20 MHz clock; counts are derived from nanoseconds.
`ifndef HBF_MAP_SVH
`define HBF_MAP_SVH
`define HBF_CLK_MHZ       20
`define HBF_NS2CYC(ns)    ((((ns) * `HBF_CLK_MHZ) + 999) / 1000)
`define HBF_OC_NS         1000
`define HBF_BLANK_NS      11500
`define HBF_TOFF_NS       20500
`define HBF_OC_CYC        `HBF_NS2CYC(`HBF_OC_NS)
`define HBF_BLANK_CYC     `HBF_NS2CYC(`HBF_BLANK_NS)
`define HBF_TOFF_CYC      `HBF_NS2CYC(`HBF_TOFF_NS)
`define HBF_ILIM_NOM_MA   13'h1964
`define HBF_ILIM_WARN_MA  13'h09c4
`define HBF_ILIM_HYST_MA  13'h00fa
`define HBF_ILIM_STEP_MA  13'h00fa
`define HBF_ST_UV_BIT     10
`define HBF_ST_OC_A_BIT   0
`define HBF_ST_OC_B_BIT   1
`define HBF_ST_RESET      16'h0000
`endif

//--- hw/hbf_pkg.sv
// Types shared by the protection and drive-sequencing block.
// Assumes the map header supplies all numeric constants.
package hbf_pkg;
	typedef enum logic [3:0] {
		LIM_IDLE  = 4'h1,
		LIM_BLANK = 4'h2,
		LIM_OFF   = 4'h4,
		LIM_HOLD  = 4'h8
	} hbf_lim_e;

	// Supply and temperature detector levels
	typedef struct packed {
		logic vbat_uv;
		logic vcc_uv;
		logic over_temp;
		logic temp_warn;
	} hbf_sense_s;

	// One-cycle command pulses from the serial interface
	typedef struct packed {
		logic uv_clr;
		logic hiz_rel;
	} hbf_cmd_s;
endpackage : hbf_pkg

//--- hw/hbf_deadtime.sv
// One bridge leg: gate sequencing with monitored high-side turn-off.
// Assumes hs_gate_off is the synchronous gate-voltage monitor level.
`timescale 1ns/1ps
`include "hbf_map.svh"
module hbf_deadtime import hbf_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Control
	input  wire logic en,
	input  wire logic want_hs,
	input  wire logic want_ls,
	input  wire logic hs_gate_off,
	// Gates
	output logic      hs_on,
	output logic      ls_on
);
	always_ff @(posedge clk) begin
		if (srst || !en) begin
			// Disable turns both gates off at once
			hs_on <= 1'b0;
			ls_on <= 1'b0;
		end else begin
			hs_on <= want_hs && !want_ls && !ls_on;
			// Low side only once the high side is seen off
			ls_on <= want_ls && !want_hs && !hs_on && hs_gate_off;
		end
	end
endmodule : hbf_deadtime

//--- hw/hbf_limiter.sv
// Chopper current limiter for one channel: blanking and minimum off-time.
// Assumes above_hi and below_lo come from comparators at the set levels.
`timescale 1ns/1ps
`include "hbf_map.svh"
module hbf_limiter import hbf_pkg::*; #(
	parameter int BLANK_CYC = `HBF_BLANK_CYC,
	parameter int TOFF_CYC  = `HBF_TOFF_CYC
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Comparators
	input  wire logic run,
	input  wire logic above_hi,
	input  wire logic below_lo,
	// Limit state
	output logic      limit
);
	hbf_lim_e   st_q;
	logic [9:0] cnt_q;

	always_ff @(posedge clk) begin
		if (srst || !run) begin
			st_q  <= LIM_IDLE;
			cnt_q <= 10'h000;
		end else begin
			unique case (st_q)
				LIM_IDLE: if (above_hi) begin
					st_q  <= LIM_BLANK;
					cnt_q <= 10'(BLANK_CYC - 1);
				end
				LIM_BLANK: if (cnt_q != 10'h000) begin
					cnt_q <= cnt_q - 10'h001;
				end else if (above_hi) begin
					st_q  <= LIM_OFF;
					cnt_q <= 10'(TOFF_CYC - 1);
				end else begin
					st_q <= LIM_IDLE;
				end
				LIM_OFF: if (cnt_q != 10'h000) begin
					cnt_q <= cnt_q - 10'h001;
				end else begin
					st_q <= below_lo ? LIM_IDLE : LIM_HOLD;
				end
				LIM_HOLD: if (below_lo) begin
					st_q <= LIM_IDLE;
				end
				default: st_q <= LIM_IDLE;
			endcase
		end
	end

	always_comb begin
		limit = (st_q == LIM_OFF) || (st_q == LIM_HOLD);
	end
endmodule : hbf_limiter

//--- hw/hbf_top.sv
// Protection and drive sequencing for a dual H-bridge motor driver.
// Assumes all inputs synchronous to clk; serial link decoded outside.
// Functional notes
// - Low side on only after high side off
// - Open-drain fault flags, one per channel, independent
// - Supply fault ends: drive and flag resume
// - Logic-supply undervoltage status bit stays latched
// - Enable restart pulse also clears that bit
// - Overcurrent after 1 us: latch flag, Hi-Z
// - Enable edge releases latched overcurrent flag
// - Serial PWM: leave Hi-Z at duty-on (an enable edge releases at once)
// - Direct PWM: leave Hi-Z immediately
// - While disabled, release only on enabling
// - Half-bridge: only faulty output goes Hi-Z
// - Half-bridge: release on command or enabling
// - Overtemperature flag recovers automatically
// - Trip 6.5 A, release 0.25 A lower
// - Sixteen threshold pairs; four when combined
// - Limit asserts after 11.5 us blanking
// - Limit forces short brake, starts off-time
// - After 20.5 us and low current resume
// - Current still high: brake until below
// - PWM ignored during minimum off-time
// - PWM low during blanking brakes at once
// - Combined mode: second enables reach gates only
// - Disabling turns outputs off without dead time
// - Temperature warning lowers trip to 2.5 A
`timescale 1ns/1ps
`include "hbf_map.svh"
module hbf_top import hbf_pkg::*; #(
	parameter int OC_CYC    = `HBF_OC_CYC,
	parameter int BLANK_CYC = `HBF_BLANK_CYC,
	parameter int TOFF_CYC  = `HBF_TOFF_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Mode straps
	input  wire logic        combined_mode,
	input  wire logic        half_mode,
	input  wire logic        serial_pwm,
	// Enables: first channel, then {active-low, active-high} second
	input  wire logic        drive_enable_hi,
	input  wire logic        drive_enable_lo,
	input  wire logic [1:0]  second_channel_enables,
	// Drive commands
	input  wire logic [3:0]  bridge_pwm_in,
	input  wire logic [3:0]  spi_pwm,
	input  wire logic [1:0]  spi_duty_on,
	input  wire hbf_cmd_s    cmd,
	input  wire logic [3:0]  ilim_sel_a,
	input  wire logic [3:0]  ilim_sel_b,
	// Analog detectors
	input  wire hbf_sense_s  sense,
	input  wire logic [3:0]  oc_det,
	input  wire logic [1:0]  cur_above_hi,
	input  wire logic [1:0]  cur_below_lo,
	input  wire logic [3:0]  hs_gate_off,
	// Gates
	output logic      [3:0]  hs_on,
	output logic      [3:0]  ls_on,
	// Threshold levels in mA per channel
	output logic      [12:0] ilim_hi_ma [2],
	output logic      [12:0] ilim_lo_ma [2],
	// Status and fault flags (open drain)
	output logic      [15:0] status_word_one,
	output logic             fault_flag_out_a_o,
	output logic             fault_flag_out_a_oe,
	output logic             fault_flag_out_b_o,
	output logic             fault_flag_out_b_oe
);
	logic        en_hi_q, en_lo_q, en2_hi_q, en2_lo_q;
	logic [1:0]  en_raw, en_ch, restart, lim, flag_q, oc_flag_q, pend_q;
	logic [1:0]  rel_ok;
	logic [3:0]  oc_hit, hiz_q, want_hs, want_ls, src, gate_en;
	logic [4:0]  oc_cnt_q [4];
	logic        uv_any, uv_st_q;

	// Trip level from a selection code
	function automatic logic [12:0] ilim_of(input logic [3:0] sel,
			input logic comb, input logic warn);
		logic [3:0] s;
		s = comb ? {2'b00, sel[1:0]} : sel;
		if (warn)
			ilim_of = `HBF_ILIM_WARN_MA;
		else
			ilim_of = 13'(`HBF_ILIM_NOM_MA - {9'h000, s} * `HBF_ILIM_STEP_MA);
	endfunction : ilim_of

	// Enable edges; combined mode logic uses first-channel pins
	always_ff @(posedge clk) begin
		if (srst) begin
			en_hi_q  <= 1'b0;
			en_lo_q  <= 1'b1;
			en2_hi_q <= 1'b0;
			en2_lo_q <= 1'b1;
		end else begin
			en_hi_q  <= drive_enable_hi;
			en_lo_q  <= drive_enable_lo;
			en2_hi_q <= second_channel_enables[0];
			en2_lo_q <= second_channel_enables[1];
		end
	end

	always_comb begin
		en_raw[0]  = drive_enable_hi && !drive_enable_lo;
		en_raw[1]  = second_channel_enables[0] && !second_channel_enables[1];
		en_ch[0]   = en_raw[0];
		en_ch[1]   = combined_mode ? en_raw[0] : en_raw[1];
		// Rising active-high or falling active-low enable
		restart[0] = en_raw[0] && ((drive_enable_hi && !en_hi_q)
				|| (!drive_enable_lo && en_lo_q));
		restart[1] = combined_mode ? restart[0] : (en_raw[1]
				&& ((second_channel_enables[0] && !en2_hi_q)
				|| (!second_channel_enables[1] && en2_lo_q)));
		uv_any     = sense.vbat_uv || sense.vcc_uv;
		src        = serial_pwm ? spi_pwm : bridge_pwm_in;
	end

	// Latched logic-supply undervoltage status; set wins
	always_ff @(posedge clk) begin
		if (srst)
			uv_st_q <= 1'b0;
		else if (sense.vcc_uv)
			uv_st_q <= 1'b1;
		else if (cmd.uv_clr || restart[0])
			uv_st_q <= 1'b0;
	end

	// Overcurrent persistence filter per output
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_oc
			always_ff @(posedge clk) begin
				if (srst || !oc_det[gi])
					oc_cnt_q[gi] <= 5'h00;
				else if (!oc_hit[gi])
					oc_cnt_q[gi] <= oc_cnt_q[gi] + 5'h01;
			end
			assign oc_hit[gi] = oc_det[gi] && (oc_cnt_q[gi] == 5'(OC_CYC - 1));

			// Hi-Z latch and release per output; set wins
			always_ff @(posedge clk) begin
				if (srst)
					hiz_q[gi] <= 1'b0;
				else if (half_mode ? oc_hit[gi]
						: (combined_mode ? |oc_hit
						: |oc_hit[gi/2*2 +: 2]))
					hiz_q[gi] <= 1'b1;
				else if (restart[gi/2])
					hiz_q[gi] <= 1'b0;
				else if (half_mode && rel_ok[gi/2])
					hiz_q[gi] <= 1'b0;
				else if (!half_mode && !serial_pwm && rel_ok[gi/2])
					hiz_q[gi] <= 1'b0;
				else if (!half_mode && serial_pwm && pend_q[gi/2]
						&& spi_duty_on[gi/2])
					hiz_q[gi] <= 1'b0;
			end
		end

		for (gi = 0; gi < 2; gi++) begin : g_ch
			// Serial command acts only while enabled
			assign rel_ok[gi] = restart[gi] || (cmd.hiz_rel && en_ch[gi]);

			always_ff @(posedge clk) begin
				if (srst)
					oc_flag_q[gi] <= 1'b0;
				else if (|oc_hit[gi*2 +: 2])
					oc_flag_q[gi] <= 1'b1;
				else if (restart[gi])
					oc_flag_q[gi] <= 1'b0;
			end

			always_ff @(posedge clk) begin
				if (srst || !(|hiz_q[gi*2 +: 2]))
					pend_q[gi] <= 1'b0;
				else if (rel_ok[gi])
					pend_q[gi] <= 1'b1;
			end

			// Live supply and temperature terms
			always_ff @(posedge clk) begin
				if (srst)
					flag_q[gi] <= 1'b0;
				else
					flag_q[gi] <= uv_any || sense.over_temp || oc_flag_q[gi];
			end

			always_ff @(posedge clk) begin
				if (srst) begin
					ilim_hi_ma[gi] <= `HBF_ILIM_NOM_MA;
					ilim_lo_ma[gi] <= 13'(`HBF_ILIM_NOM_MA - `HBF_ILIM_HYST_MA);
				end else begin
					ilim_hi_ma[gi] <= ilim_of(gi == 0 ? ilim_sel_a : ilim_sel_b,
						combined_mode, sense.temp_warn);
					ilim_lo_ma[gi] <= 13'(ilim_of(gi == 0 ? ilim_sel_a
						: ilim_sel_b, combined_mode, sense.temp_warn)
						- `HBF_ILIM_HYST_MA);
				end
			end

			// Separate limiter per channel
			hbf_limiter #(
				.BLANK_CYC (BLANK_CYC),
				.TOFF_CYC  (TOFF_CYC)
			) u_lim (
				.clk      (clk),
				.srst     (srst),
				.run      (en_ch[gi] && !half_mode && !uv_any),
				.above_hi (cur_above_hi[gi]),
				.below_lo (cur_below_lo[gi]),
				.limit    (lim[gi])
			);
		end
	endgenerate

	// Wanted gate states per leg
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			logic a, b, l;
			a = combined_mode ? src[0] : src[2*c];
			b = combined_mode ? src[1] : src[2*c+1];
			l = combined_mode ? lim[0] : lim[c];
			// Limit brakes and masks PWM PWM low brakes
			want_hs[2*c]   = a && !b && !l;
			want_hs[2*c+1] = b && !a && !l;
			want_ls[2*c]   = !want_hs[2*c];
			want_ls[2*c+1] = !want_hs[2*c+1];
		end
		if (half_mode) begin
			want_hs = {2'b00, src[1:0]};
			want_ls = {2'b00, ~src[1:0]};
		end
		for (int i = 0; i < 4; i++)
			gate_en[i] = (i < 2 ? en_raw[0] : en_raw[1]) && !uv_any
				&& !sense.over_temp && !hiz_q[i];
	end

	generate
		for (gi = 0; gi < 4; gi++) begin : g_leg
			hbf_deadtime u_dt (
				.clk         (clk),
				.srst        (srst),
				.en          (gate_en[gi]),
				.want_hs     (want_hs[gi]),
				.want_ls     (want_ls[gi]),
				.hs_gate_off (hs_gate_off[gi]),
				.hs_on       (hs_on[gi]),
				.ls_on       (ls_on[gi])
			);
		end
	endgenerate

	always_comb begin
		status_word_one                   = `HBF_ST_RESET;
		status_word_one[`HBF_ST_UV_BIT]   = uv_st_q;
		status_word_one[`HBF_ST_OC_A_BIT] = oc_flag_q[0];
		status_word_one[`HBF_ST_OC_B_BIT] = oc_flag_q[1];
		fault_flag_out_a_o  = 1'b0;
		fault_flag_out_b_o  = 1'b0;
		fault_flag_out_a_oe = flag_q[0];
		fault_flag_out_b_oe = flag_q[1];
	end

	// Checks
	chk_ls_after_hs: assert property (@(posedge clk) disable iff (srst)
		$rose(ls_on[0]) |-> $past(hs_gate_off[0]) && !$past(hs_on[0]))
		else $error("low side on before high side seen off");
	chk_flag_uv_low: assert property (@(posedge clk) disable iff (srst)
		sense.vbat_uv |=> fault_flag_out_a_oe && fault_flag_out_b_oe)
		else $error("fault flag not driven on supply fault");
	chk_uv_resume: assert property (@(posedge clk) disable iff (srst)
		!uv_any && !sense.over_temp && !oc_flag_q[0] |=> !fault_flag_out_a_oe)
		else $error("fault flag held without cause");
	chk_uv_sticky: assert property (@(posedge clk) disable iff (srst)
		$fell(sense.vcc_uv) && !cmd.uv_clr && !restart[0] |-> uv_st_q)
		else $error("undervoltage status lost");
	chk_uv_restart: assert property (@(posedge clk) disable iff (srst)
		restart[0] && !sense.vcc_uv |=> !status_word_one[`HBF_ST_UV_BIT])
		else $error("restart did not clear undervoltage status");
	chk_oc_persist: assert property (@(posedge clk) disable iff (srst)
		$rose(oc_flag_q[0]) |-> $past(oc_det[0], 1) || $past(oc_det[1], 1))
		else $error("overcurrent latched without persistence");
	chk_oc_release: assert property (@(posedge clk) disable iff (srst)
		oc_flag_q[0] && restart[0] && !oc_hit[0] && !oc_hit[1] |=> !oc_flag_q[0])
		else $error("enable edge did not release overcurrent flag");
	chk_serial_wait: assert property (@(posedge clk) disable iff (srst)
		serial_pwm && !half_mode && hiz_q[0] && !spi_duty_on[0]
		&& !restart[0] |=> hiz_q[0])
		else $error("serial drive left Hi-Z before duty-on");
	chk_direct_release: assert property (@(posedge clk) disable iff (srst)
		!serial_pwm && !half_mode && rel_ok[0] && !(|oc_hit) |=> !hiz_q[0])
		else $error("direct drive kept Hi-Z after release");
	chk_restart_release: assert property (@(posedge clk) disable iff (srst)
		restart[0] && !(|oc_hit) |=> !hiz_q[0])
		else $error("enabling did not release Hi-Z");
	chk_half_single: assert property (@(posedge clk) disable iff (srst)
		half_mode && oc_hit[0] && !oc_hit[1] && !hiz_q[1] |=> !hiz_q[1])
		else $error("half-bridge fault spread to another output");
	chk_half_release: assert property (@(posedge clk) disable iff (srst)
		half_mode && rel_ok[0] && !oc_hit[0] |=> !hiz_q[0])
		else $error("half-bridge output kept Hi-Z after release");
	chk_flag_b_free: assert property (@(posedge clk) disable iff (srst)
		!sense.over_temp && !uv_any && !oc_flag_q[1] |=> !fault_flag_out_b_oe)
		else $error("second fault flag held without cause");
	chk_oc_flag_b: assert property (@(posedge clk) disable iff (srst)
		|oc_hit[3:2] |=> oc_flag_q[1])
		else $error("second channel overcurrent not latched");
	chk_pwm_masked: assert property (@(posedge clk) disable iff (srst)
		lim[0] && !half_mode |-> !want_hs[0] && !want_hs[1])
		else $error("pwm reached high side during off-time");
	chk_pwm_low_brake: assert property (@(posedge clk) disable iff (srst)
		!half_mode && !combined_mode && !src[0] && !src[1]
		|-> want_ls[0] && want_ls[1])
		else $error("pwm low did not brake");
	chk_comb_enables: assert property (@(posedge clk) disable iff (srst)
		combined_mode |-> en_ch[1] == en_raw[0] && restart[1] == restart[0])
		else $error("combined mode logic used second enables");
	chk_warn_level: assert property (@(posedge clk) disable iff (srst)
		sense.temp_warn |=> ilim_hi_ma[0] == `HBF_ILIM_WARN_MA)
		else $error("temperature warning did not lower trip level");
	chk_lo_below_hi: assert property (@(posedge clk) disable iff (srst)
		ilim_lo_ma[0] == 13'(ilim_hi_ma[0] - `HBF_ILIM_HYST_MA))
		else $error("release level not below trip level");
	chk_blank_end: assert property (@(posedge clk) disable iff (srst)
		$rose(lim[0]) |-> $past(cur_above_hi[0]))
		else $error("limit without current above trip");
	chk_limit_brake: assert property (@(posedge clk) disable iff (srst)
		lim[0] && !half_mode |-> want_ls[0] && want_ls[1])
		else $error("limit did not force short brake");
	chk_off_min: assert property (@(posedge clk) disable iff (srst)
		$rose(lim[0]) && en_ch[0] && !uv_any |-> lim[0] [*8])
		else $error("minimum off-time cut short");
	chk_disable_off: assert property (@(posedge clk) disable iff (srst)
		!en_raw[0] |=> !hs_on[0] && !ls_on[0] && !hs_on[1] && !ls_on[1])
		else $error("disable did not turn outputs off");
	cov_limit: cover property (@(posedge clk) disable iff (srst) $rose(lim[0]));
	cov_oc: cover property (@(posedge clk) disable iff (srst) $rose(oc_flag_q[0]));
	cov_uv_clr: cover property (@(posedge clk) disable iff (srst) $fell(uv_st_q));
	cov_ser_rel: cover property (@(posedge clk) disable iff (srst)
		serial_pwm && $fell(hiz_q[0]));
	cov_half_trip: cover property (@(posedge clk) disable iff (srst)
		half_mode && $rose(hiz_q[0]));
endmodule : hbf_top

//--- dv/hbf_host_model.sv
// Far-side model: gate-off monitor echo and pulled-up fault flag lines.
// Assumes the gate drives and flag enables of the design are wired in.
`timescale 1ns/1ps
module hbf_host_model (
	// Clock
	input  wire logic       clk,
	// Design side
	input  wire logic [3:0] hs_on,
	input  wire logic       flag_a_o,
	input  wire logic       flag_a_oe,
	input  wire logic       flag_b_o,
	input  wire logic       flag_b_oe,
	// Sensed levels
	output logic      [3:0] hs_gate_off,
	output logic            flag_a_pin,
	output logic            flag_b_pin
);
	initial hs_gate_off = 4'hf;
	// Gate discharge is seen one cycle after the drive drops
	always @(posedge clk) begin
		hs_gate_off <= ~hs_on;
	end
	// Pull-up to the host supply unless the pin is pulled low
	assign flag_a_pin = flag_a_oe ? flag_a_o : 1'b1;
	assign flag_b_pin = flag_b_oe ? flag_b_o : 1'b1;
endmodule : hbf_host_model

//--- dv/hbf_top_tb_top.sv
// Self-checking bench for the protection and drive-sequencing block.
// Assumes pwm level 1 selects the high side of a leg, 0 the low side.
`timescale 1ns/1ps
module hbf_top_tb_top import hbf_pkg::*; ;
	localparam int OC = 3, BL = 8, TO = 12;
	logic        clk, srst, comb, half, ser, en_hi, en_lo;
	logic [1:0]  en_b, duty, above, below;
	logic [3:0]  pwm, spwm, sel_a, sel_b, oc, goff, hs, ls, ls_p, off_p;
	hbf_cmd_s    cmd;
	hbf_sense_s  sense;
	logic [12:0] hi_ma [2];
	logic [12:0] lo_ma [2];
	logic [15:0] st;
	logic        fa_o, fa_oe, fb_o, fb_oe, fa, fb;
	int          fail_count, tests_run;

	hbf_top #(.OC_CYC(OC), .BLANK_CYC(BL), .TOFF_CYC(TO)) hbf_top_inst (
		.clk, .srst, .cmd, .sense,
		.combined_mode(comb), .half_mode(half), .serial_pwm(ser),
		.drive_enable_hi(en_hi), .drive_enable_lo(en_lo),
		.second_channel_enables(en_b), .bridge_pwm_in(pwm),
		.spi_pwm(spwm), .spi_duty_on(duty), .ilim_sel_a(sel_a),
		.ilim_sel_b(sel_b), .oc_det(oc), .cur_above_hi(above),
		.cur_below_lo(below), .hs_gate_off(goff), .hs_on(hs),
		.ls_on(ls), .ilim_hi_ma(hi_ma), .ilim_lo_ma(lo_ma),
		.status_word_one(st), .fault_flag_out_a_o(fa_o),
		.fault_flag_out_a_oe(fa_oe), .fault_flag_out_b_o(fb_o),
		.fault_flag_out_b_oe(fb_oe));

	hbf_host_model hbf_host_model_inst (
		.clk, .hs_on(hs), .flag_a_o(fa_o), .flag_a_oe(fa_oe),
		.flag_b_o(fb_o), .flag_b_oe(fb_oe), .hs_gate_off(goff),
		.flag_a_pin(fa), .flag_b_pin(fb));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic wait_ls(input int leg, input logic v, input int n);
		for (int i = 0; i < n && ls[leg] !== v; i++) cyc(1);
		check(ls[leg], v);
	endtask : wait_ls

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop

	// Trip over-current on the given outputs, then clear the comparator
	task automatic oc_trip(input logic [3:0] m);
		oc = m;
		cyc(OC + 1);
		oc = 4'h0;
		cyc(2);
	endtask : oc_trip

	task automatic en_pulse;
		en_hi = 1'b0;
		cyc(2);
		en_hi = 1'b1;
		cyc(3);
	endtask : en_pulse

	task automatic hiz_pulse;
		cmd.hiz_rel = 1'b1;
		cyc(1);
		cmd.hiz_rel = 1'b0;
		cyc(3);
	endtask : hiz_pulse

	// Chopper run on channel A; hold keeps current above the low level
	task automatic lim(input logic hold);
		above = 2'b01;
		cyc(BL - 1);
		check(ls[0], 1'b0);
		wait_ls(0, 1'b1, 6);
		above = 2'b00;
		below = {1'b0, ~hold};
		pwm = 4'b0110;
		cyc(2);
		check(hs[1], 1'b0);
		check(hs[2], 1'b1);
		pwm = 4'b0101;
		cyc(TO - 6);
		check(ls[0], 1'b1);
		if (hold) begin
			cyc(10);
			check(ls[0], 1'b1);
			below = 2'b01;
		end
		wait_ls(0, 1'b0, 12);
		below = 2'b00;
		cyc(4);
		$display("test done: limiter hold=%0d", hold);
	endtask : lim

	// Through-current watch on every leg
	always @(posedge clk) begin
		if (srst === 1'b0)
			check({hs & ls, ls & ~ls_p & ~off_p}, 8'h00);
		ls_p  <= ls;
		off_p <= goff;
	end

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		#250000;
		fail_count++;
		report_and_stop;
	end

	initial begin
		{srst, comb, half, ser, en_hi} = 5'h10;
		{en_lo, en_b, duty, above, below} = 9'h100;
		{pwm, spwm, sel_a, sel_b, oc} = 20'h0;
		cmd = '0;
		sense = '0;
		cyc(3);
		srst = 1'b0;
		cyc(1);
		check(st, 16'h0000);
		check({hs, ls}, 8'h00);
		check(hi_ma[0], 13'h1964);
		check(lo_ma[0], 13'h186a);
		for (int s = 0; s < 16; s++) begin
			sel_a = 4'(s);
			sel_b = 4'(15 - s);
			cyc(2);
			check(hi_ma[0], 16'(6500 - s * 250));
			check(lo_ma[0], 16'(6250 - s * 250));
			check(hi_ma[1], 16'(6500 - (15 - s) * 250));
		end
		comb = 1'b1;
		sel_a = 4'h7;
		cyc(2);
		check(hi_ma[0], 13'h1676);
		{comb, sel_a, sel_b} = 9'h0;
		sense.temp_warn = 1'b1;
		cyc(2);
		check(hi_ma[0], 13'h09c4);
		check(lo_ma[0], 13'h08ca);
		sense = '0;
		$display("test done: thresholds");
		{en_hi, en_lo, en_b, pwm} = 8'h95;
		cyc(4);
		check({hs, ls}, 8'h5a);
		sense.vbat_uv = 1'b1;
		cyc(2);
		check({fa, hs[0]}, 2'b00);
		sense = '0;
		cyc(4);
		check({fa, hs[0]}, 2'b11);
		sense.vcc_uv = 1'b1;
		cyc(2);
		sense = '0;
		cyc(2);
		check({st[10], fa}, 2'b11);
		cmd.uv_clr = 1'b1;
		cyc(1);
		cmd.uv_clr = 1'b0;
		cyc(2);
		check(st[10], 1'b0);
		sense.vcc_uv = 1'b1;
		cyc(2);
		sense = '0;
		en_pulse;
		check(st[10], 1'b0);
		sense.over_temp = 1'b1;
		cyc(2);
		check(fa, 1'b0);
		sense = '0;
		cyc(2);
		check(fa, 1'b1);
		$display("test done: supply and temperature");
		en_hi = 1'b0;
		cyc(1);
		check({hs[1:0], ls[1:0], hs[2]}, 5'h01);
		en_hi = 1'b1;
		cyc(4);
		oc = 4'h1;
		cyc(OC - 1);
		oc = 4'h0;
		cyc(3);
		check(st[0], 1'b0);
		oc_trip(4'h1);
		check({st[0], fa, fb}, 3'b101);
		check({hs[1:0], ls[1:0], hs[2]}, 5'h01);
		hiz_pulse;
		check({hs[0], fa}, 2'b10);
		en_pulse;
		check(fa, 1'b1);
		{ser, spwm} = 5'h15;
		cyc(3);
		oc_trip(4'h1);
		hiz_pulse;
		check(hs[0], 1'b0);
		duty = 2'b01;
		cyc(1);
		duty = 2'b00;
		cyc(3);
		check(hs[0], 1'b1);
		en_pulse;
		check(fa, 1'b1);
		oc_trip(4'h1);
		en_pulse;
		check(hs[0], 1'b1);
		ser = 1'b0;
		$display("test done: over-current");
		{half, pwm} = 5'h11;
		cyc(4);
		oc_trip(4'h1);
		check({hs[0], ls[1]}, 2'b01);
		hiz_pulse;
		check(hs[0], 1'b1);
		{half, pwm} = 5'h05;
		en_pulse;
		cyc(2);
		lim(1'b0);
		lim(1'b1);
		above = 2'b01;
		cyc(2);
		pwm[0] = 1'b0;
		cyc(3);
		check(ls[0], 1'b1);
		pwm[0] = 1'b1;
		above = 2'b00;
		cyc(BL + 4);
		check(ls[0], 1'b0);
		$display("test done: blanking");
		comb = 1'b1;
		oc_trip(4'h4);
		check({st[1], fa, fb, hs[0]}, 4'b1100);
		en_pulse;
		check({fa, fb, hs[2]}, 3'b111);
		$display("test done: combined");
		report_and_stop;
	end
endmodule : hbf_top_tb_top
